// >>> logic/i2c_reg_slave_pkg.sv
// Purpose: Shared constants, carriers and state encodings of the I2C register target
// Assumes: 8-bit register pointer, 16-bit register words
// Notes: Only the output driver setup register is held by this block
package i2c_reg_slave_pkg;

    // Register map
    localparam logic [7:0] DRV_SETUP_OFFSET = 8'h06;
    localparam logic [15:0] DRV_SETUP_RESET = 16'h0000;
    localparam int DRV_DIV_BIT = 3;
    localparam int DRV_CODE_MSB = 2;
    localparam int DRV_USED_MSB = 3;
    localparam logic [2:0] DRV_CODE_LVDS_HCSL = 3'h0;
    localparam logic [2:0] DRV_CODE_LVPECL = 3'h6;
    localparam logic [15:0] UNMAPPED_READ = 16'h0000;

    // Addressing
    localparam logic [6:0] DEV_ADDR_BASE = 7'h60;
    localparam int PIN_SEL_HIGH_POS = 3;
    localparam int PIN_SEL_LOW_POS = 1;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [7:0] PTR_STEP = 8'h01;

    // Byte framing
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] BYTE_LAST = 4'h7;
    localparam logic [3:0] BIT_STEP = 4'h1;
    localparam logic RW_READ = 1'b1;

    typedef struct packed {
        logic div_bypass;
        logic [2:0] drv_code;
    } driver_setup_t;

    typedef struct packed {
        logic we;
        logic [7:0] addr;
        logic [15:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic scl;
        logic sda;
        logic sel_high;
        logic sel_low;
    } bus_pins_t;

    typedef enum logic [2:0] {
        BUS_IDLE,
        BUS_RX,
        BUS_ACK_OUT,
        BUS_FETCH,
        BUS_TX,
        BUS_ACK_IN
    } bus_state_t;

    typedef enum logic [1:0] {
        KIND_DEV,
        KIND_REG,
        KIND_MSB,
        KIND_LSB
    } byte_kind_t;

endpackage

// >>> logic/pin_sync.sv
// Purpose: Two-flop synchroniser for the bus and address-select pins
// Assumes: Inputs are asynchronous to clk
// Notes: First stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module pin_sync
    import i2c_reg_slave_pkg::*;
#(
    parameter int WIDTH = 4
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    // Refuse an empty chain at elaboration
    if (WIDTH < 1) begin : g_bad_width
        $error("pin_sync needs WIDTH of at least 1");
    end

    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } sync_state_t;

    sync_state_t st_ff;
    sync_state_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.first = async_in;
        nxt_st.second = st_ff.first;
    end

    // Idle bus lines are high, so the chain resets to ones
    always_ff @(posedge clk) begin
        if (reset) begin
            st_ff <= '1;
        end else if (clk_en) begin
            st_ff <= nxt_st;
        end
    end

    assign sync_out = st_ff.second;
endmodule
`default_nettype wire

// >>> logic/driver_setup_store.sv
// Purpose: Register store behind the pointer, holding the output driver setup word
// Assumes: One write request per cycle at most
// Notes: Unmapped addresses read zero and ignore writes
`timescale 1ns/1ps
`default_nettype none
module driver_setup_store
    import i2c_reg_slave_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire reg_req_t req,
    input wire logic [7:0] rd_addr,
    output logic [15:0] rd_data,
    output driver_setup_t setup
);
    typedef struct packed {
        driver_setup_t setup;
        logic [15:0] rd_data;
    } store_state_t;

    store_state_t st_ff;
    store_state_t nxt_st;

    function automatic logic hits_setup(input logic [7:0] addr);
        hits_setup = (addr == DRV_SETUP_OFFSET);
    endfunction

    always_comb begin
        nxt_st = st_ff;
        if (req.we && hits_setup(req.addr)) begin
            // Upper twelve bits dropped on write
            nxt_st.setup = req.wdata[DRV_USED_MSB:0];
        end
        if (hits_setup(rd_addr)) begin
            nxt_st.rd_data = {12'h000, st_ff.setup};
        end else begin
            nxt_st.rd_data = UNMAPPED_READ;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_ff <= {DRV_SETUP_RESET[DRV_USED_MSB:0], 16'h0000};
        end else if (clk_en) begin
            st_ff <= nxt_st;
        end
    end

    assign rd_data = st_ff.rd_data;
    assign setup = st_ff.setup;

    a_reserved_zero: assert property (@(posedge clk) disable iff (reset)
        rd_data[15:4] == 12'h000)
        else $error("reserved driver setup bits read nonzero");

    a_divider_default: assert property (@(posedge clk)
        $past(reset) && !reset |-> setup.div_bypass == 1'b0)
        else $error("divider select not at divide-by-two after reset");
endmodule
`default_nettype wire

// >>> logic/i2c_reg_slave.sv
// Purpose: I2C target giving a bus controller access to 16-bit configuration words
// Assumes: clk at 200 MHz, far faster than the serial clock
// Notes: The target never stretches the serial clock
// Operation
// - Driver setup bits 15:4 read zero, ignore writes
// - Bit 3 picks divide-by-two, default zero
// - Data changes only while serial clock low
// - Data edges with clock high mark START/STOP
// - Repeated START restarts address reception
// - Idle bus lines released, pulled high
// - Eight-bit bytes, MSB first, unlimited count
// - Receiver pulls data low on ninth clock
// - Not-acknowledge only for a foreign device address
// - Controller nack keeps the target sending data
// - First byte: 7-bit address plus direction
// - Register address byte follows the device address
// - Pointer advances per word, wraps 255 to 0
// - Words travel as two bytes, high first
// - Plain read starts at pointer, reset zero
// - Factory option: fixed low four address bits
// - Pin option: two pins pick four addresses
`timescale 1ns/1ps
`default_nettype none
module i2c_reg_slave
    import i2c_reg_slave_pkg::*;
#(
    parameter bit ADDR_BY_PINS = 1'b1,
    parameter logic [3:0] FACTORY_ADDR_LOW = 4'h0
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic addr_select_low_pin,
    input wire logic addr_select_high_pin,
    output driver_setup_t driver_setup,
    output logic bus_busy
);
    typedef struct packed {
        logic scl_prev;
        logic sda_prev;
        bus_state_t state;
        byte_kind_t kind;
        logic rw;
        logic ack_seen;
        logic [3:0] bit_cnt;
        logic [7:0] shift;
        logic [7:0] msb_hold;
        logic [15:0] word;
        logic [7:0] ptr;
        logic sda_oe;
        reg_req_t req;
    } slave_state_t;

    slave_state_t st_ff;
    slave_state_t nxt_st;
    bus_pins_t pins_s;
    logic [15:0] rd_data;
    logic [6:0] own_addr;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;

    // Pins pass two flops before decoding
    pin_sync #(
        .WIDTH(4)
    ) u_sync (
        .clk(clk),
        .reset(reset),
        .clk_en(clk_en),
        .async_in({scl_in, sda_in, addr_select_high_pin, addr_select_low_pin}),
        .sync_out(pins_s)
    );

    driver_setup_store u_store (
        .clk(clk),
        .reset(reset),
        .clk_en(clk_en),
        .req(st_ff.req),
        .rd_addr(nxt_st.ptr),
        .rd_data(rd_data),
        .setup(driver_setup)
    );

    // Own address from pins or the factory setting
    always_comb begin
        if (ADDR_BY_PINS) begin
            own_addr = DEV_ADDR_BASE;
            own_addr[PIN_SEL_HIGH_POS] = pins_s.sel_high;
            own_addr[PIN_SEL_LOW_POS] = pins_s.sel_low;
        end else begin
            own_addr = {DEV_ADDR_BASE[6:4], FACTORY_ADDR_LOW};
        end
    end

    // Line events from the synchronised levels
    assign scl_rise = pins_s.scl & ~st_ff.scl_prev;
    assign scl_fall = ~pins_s.scl & st_ff.scl_prev;
    assign start_ev = pins_s.scl & st_ff.scl_prev & st_ff.sda_prev & ~pins_s.sda;
    assign stop_ev = pins_s.scl & st_ff.scl_prev & ~st_ff.sda_prev & pins_s.sda;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.scl_prev = pins_s.scl;
        nxt_st.sda_prev = pins_s.sda;
        nxt_st.req.we = 1'b0;
        if (stop_ev) begin
            nxt_st.state = BUS_IDLE;
            nxt_st.sda_oe = 1'b0;
        end else if (start_ev) begin
            // Also a repeated START mid-transfer
            nxt_st.state = BUS_RX;
            nxt_st.kind = KIND_DEV;
            nxt_st.bit_cnt = 4'h0;
            nxt_st.sda_oe = 1'b0;
        end else begin
            unique case (st_ff.state)
                BUS_IDLE: begin
                    nxt_st.sda_oe = 1'b0;
                end
                BUS_RX: begin
                    if (scl_rise) begin
                        // Sampled in the high phase, MSB first
                        nxt_st.shift = {st_ff.shift[6:0], pins_s.sda};
                        nxt_st.bit_cnt = st_ff.bit_cnt + BIT_STEP;
                    end else if (scl_fall && st_ff.bit_cnt == BYTE_BITS) begin
                        nxt_st.bit_cnt = 4'h0;
                        nxt_st.state = BUS_ACK_OUT;
                        nxt_st.sda_oe = 1'b1;
                        unique case (st_ff.kind)
                            KIND_DEV: begin
                                if (st_ff.shift[7:1] != own_addr) begin
                                    nxt_st.state = BUS_IDLE;
                                    nxt_st.sda_oe = 1'b0;
                                end else begin
                                    nxt_st.rw = st_ff.shift[0];
                                    nxt_st.kind = (st_ff.shift[0] == RW_READ) ? KIND_MSB
                                        : KIND_REG;
                                end
                            end
                            KIND_REG: begin
                                nxt_st.ptr = st_ff.shift;
                                nxt_st.kind = KIND_MSB;
                            end
                            KIND_MSB: begin
                                nxt_st.msb_hold = st_ff.shift;
                                nxt_st.kind = KIND_LSB;
                            end
                            KIND_LSB: begin
                                nxt_st.req.we = 1'b1;
                                nxt_st.req.addr = st_ff.ptr;
                                nxt_st.req.wdata = {st_ff.msb_hold, st_ff.shift};
                                nxt_st.ptr = st_ff.ptr + PTR_STEP;
                                nxt_st.kind = KIND_MSB;
                            end
                        endcase
                    end
                end
                BUS_ACK_OUT: begin
                    // Low held through the ninth high phase, freed on its fall for a write
                    if (scl_fall) begin
                        // A read keeps the ack low until the first bit
                        nxt_st.sda_oe = (st_ff.rw == RW_READ);
                        nxt_st.state = (st_ff.rw == RW_READ) ? BUS_FETCH : BUS_RX;
                    end
                end
                BUS_FETCH: begin
                    // Read data already matches the current pointer
                    nxt_st.state = BUS_TX;
                    nxt_st.word = rd_data;
                    nxt_st.shift = rd_data[15:8];
                    nxt_st.sda_oe = ~rd_data[15];
                end
                BUS_TX: begin
                    // Data moves only after the clock falls
                    if (scl_fall) begin
                        if (st_ff.bit_cnt == BYTE_LAST) begin
                            nxt_st.bit_cnt = 4'h0;
                            nxt_st.state = BUS_ACK_IN;
                            nxt_st.sda_oe = 1'b0;
                        end else begin
                            nxt_st.shift = {st_ff.shift[6:0], 1'b0};
                            nxt_st.bit_cnt = st_ff.bit_cnt + BIT_STEP;
                            nxt_st.sda_oe = ~st_ff.shift[6];
                        end
                    end
                end
                BUS_ACK_IN: begin
                    if (scl_rise) begin
                        nxt_st.ack_seen = ~pins_s.sda;
                    end else if (scl_fall) begin
                        if (st_ff.kind == KIND_LSB) begin
                            nxt_st.ptr = st_ff.ptr + PTR_STEP;
                        end
                        if (st_ff.ack_seen) begin
                            nxt_st.state = BUS_IDLE;
                            nxt_st.sda_oe = 1'b0;
                        end else if (st_ff.kind == KIND_MSB) begin
                            nxt_st.state = BUS_TX;
                            nxt_st.kind = KIND_LSB;
                            nxt_st.shift = st_ff.word[7:0];
                            nxt_st.sda_oe = ~st_ff.word[7];
                        end else begin
                            nxt_st.state = BUS_FETCH;
                            nxt_st.kind = KIND_MSB;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_ff <= '{scl_prev: 1'b1, sda_prev: 1'b1, state: BUS_IDLE, kind: KIND_DEV,
                rw: 1'b0, ack_seen: 1'b0, bit_cnt: 4'h0, shift: 8'h00, msb_hold: 8'h00,
                word: 16'h0000, ptr: PTR_RESET, sda_oe: 1'b0, req: '0};
        end else if (clk_en) begin
            st_ff <= nxt_st;
        end
    end

    // Open-drain data line: only ever pulled low
    assign sda_out = 1'b0;
    assign sda_oe = st_ff.sda_oe;
    assign bus_busy = (st_ff.state != BUS_IDLE);

    a_start_restarts: assert property (@(posedge clk) disable iff (reset || !clk_en)
        start_ev && !stop_ev |=> st_ff.state == BUS_RX && st_ff.kind == KIND_DEV
            && !sda_oe)
        else $error("START did not restart address reception");

    a_stop_idles: assert property (@(posedge clk) disable iff (reset || !clk_en)
        stop_ev |=> st_ff.state == BUS_IDLE && !sda_oe)
        else $error("STOP did not return to idle");

    a_foreign_nack: assert property (@(posedge clk) disable iff (reset || !clk_en)
        st_ff.state == BUS_RX && st_ff.kind == KIND_DEV && scl_fall && !start_ev
            && !stop_ev && st_ff.bit_cnt == BYTE_BITS && st_ff.shift[7:1] != own_addr
            |=> !sda_oe ##1 !sda_oe)
        else $error("foreign address was acknowledged");

    a_own_ack: assert property (@(posedge clk) disable iff (reset || !clk_en)
        st_ff.state == BUS_RX && scl_fall && !start_ev && !stop_ev
            && st_ff.bit_cnt == BYTE_BITS
            && (st_ff.kind != KIND_DEV || st_ff.shift[7:1] == own_addr)
            |=> sda_oe && st_ff.state == BUS_ACK_OUT)
        else $error("received byte not acknowledged");

    a_sda_high_stable: assert property (@(posedge clk) disable iff (reset || !clk_en)
        pins_s.scl && st_ff.scl_prev && !start_ev && !stop_ev
            && st_ff.state != BUS_FETCH |=> $stable(sda_oe))
        else $error("data line moved while serial clock high");

    a_word_write: assert property (@(posedge clk) disable iff (reset || !clk_en)
        st_ff.req.we |-> st_ff.ptr == st_ff.req.addr + PTR_STEP
            && st_ff.req.wdata[7:0] == st_ff.shift)
        else $error("write word and pointer advance disagree");

    a_ptr_after_reset: assert property (@(posedge clk)
        $past(reset) && !reset |-> st_ff.ptr == PTR_RESET && !sda_oe)
        else $error("pointer not zero after reset");

    a_read_ack_release: assert property (@(posedge clk) disable iff (reset || !clk_en)
        st_ff.state == BUS_ACK_IN && scl_fall && st_ff.ack_seen && !start_ev && !stop_ev
            |=> (!sda_oe && st_ff.state == BUS_IDLE) [*2])
        else $error("line not released after controller ack");

    a_ptr_wrap: assert property (@(posedge clk) disable iff (reset || !clk_en)
        st_ff.state == BUS_ACK_IN && scl_fall && st_ff.kind == KIND_LSB && !start_ev
            && !stop_ev |=> st_ff.ptr == $past(st_ff.ptr) + PTR_STEP)
        else $error("read pointer did not advance by one");

    a_tx_release: assert property (@(posedge clk) disable iff (reset || !clk_en)
        st_ff.state == BUS_TX && scl_fall && st_ff.bit_cnt == BYTE_LAST && !start_ev
            && !stop_ev |=> !sda_oe && st_ff.state == BUS_ACK_IN)
        else $error("data line not released for the ninth clock");

    a_nack_continues: assert property (@(posedge clk) disable iff (reset || !clk_en)
        st_ff.state == BUS_ACK_IN && scl_fall && !st_ff.ack_seen && !start_ev && !stop_ev
            |=> st_ff.state == BUS_TX || st_ff.state == BUS_FETCH)
        else $error("transmission stopped after controller nack");

    a_read_keeps_line: assert property (@(posedge clk) disable iff (reset || !clk_en)
        st_ff.state == BUS_ACK_OUT && st_ff.rw == RW_READ && scl_fall && !start_ev
            && !stop_ev |=> sda_oe && st_ff.state == BUS_FETCH)
        else $error("data line released between ack and first read bit");

    a_fetch_msb: assert property (@(posedge clk) disable iff (reset || !clk_en)
        st_ff.state == BUS_FETCH && !start_ev && !stop_ev
            |=> sda_oe == !$past(rd_data[15]) && st_ff.state == BUS_TX)
        else $error("read word did not start with its top bit");

    a_idle_released: assert property (@(posedge clk) disable iff (reset || !clk_en)
        st_ff.state == BUS_IDLE |-> !sda_oe)
        else $error("data line pulled while bus idle");
endmodule
`default_nettype wire

// >>> bench/i2c_ctrl_model.sv
// Purpose: Behavioural bus controller that drives the serial clock and pulls the data line
// Assumes: The line level is resolved outside; sda_drv low pulls the data line down
// Notes: Serial clock period is 25 clk cycles (125 ns); the clock stands high between frames
`timescale 1ns/1ps
`default_nettype none
module i2c_ctrl_model (
    input wire logic clk,
    input wire logic sda_line,
    output logic scl,
    output logic sda_drv
);
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Also a repeated start when entered with the clock low
    task automatic start_cond();
        wait_clk(6);
        sda_drv = 1'b1;
        wait_clk(6);
        scl = 1'b1;
        wait_clk(6);
        sda_drv = 1'b0;
        wait_clk(6);
        scl = 1'b0;
    endtask

    task automatic stop_cond();
        wait_clk(6);
        sda_drv = 1'b0;
        wait_clk(6);
        scl = 1'b1;
        wait_clk(6);
        sda_drv = 1'b1;
        wait_clk(12);
    endtask

    // Data moves only while the clock is low
    task automatic clock_bit(input logic b, output logic seen);
        wait_clk(6);
        sda_drv = b;
        wait_clk(6);
        scl = 1'b1;
        wait_clk(6);
        seen = sda_line;
        wait_clk(7);
        scl = 1'b0;
    endtask

    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic unused;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(b[i], unused);
        end
        clock_bit(1'b1, ack);
    endtask

    // Ack low ends a read, high asks for more
    task automatic get_byte(input logic ack, output logic [7:0] b);
        logic unused;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(1'b1, b[i]);
        end
        clock_bit(ack, unused);
    endtask
endmodule
`default_nettype wire

// >>> bench/testbench.sv
// Purpose: Self-checking bench for the I2C register target
// Assumes: Select pins give the base address unless a test changes them
// Notes: The controller model drives the serial lines; the pull-up is resolved here
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import i2c_reg_slave_pkg::*;
    logic clk;
    logic reset;
    logic clk_en;
    logic sel_low;
    logic sel_high;
    logic scl;
    logic sda_drv;
    logic sda_line;
    logic sda_out;
    logic sda_oe;
    logic bus_busy;
    driver_setup_t driver_setup;
    int n_fail = 0;
    int comparisons = 0;

    // Open-drain data wire with pull-up
    assign sda_line = sda_drv & (sda_oe ? sda_out : 1'b1);

    i2c_reg_slave i2c_reg_slave_i (
        .clk(clk), .reset(reset), .clk_en(clk_en), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .addr_select_low_pin(sel_low),
        .addr_select_high_pin(sel_high), .driver_setup(driver_setup), .bus_busy(bus_busy)
    );
    i2c_ctrl_model i2c_ctrl_model_i (
        .clk(clk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv)
    );

    task automatic stop_test();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic send(input logic [7:0] b, input logic exp_ack);
        logic ack;
        i2c_ctrl_model_i.put_byte(b, ack);
        check("ack", {15'h0, ack}, {15'h0, exp_ack});
    endtask

    task automatic write_regs(input logic [6:0] dev, input logic [7:0] ra,
        input logic [15:0] w0, input logic [15:0] w1, input int n, input logic exp_ack);
        i2c_ctrl_model_i.start_cond();
        send({dev, 1'b0}, exp_ack);
        // A refused address is followed straight by STOP
        if (!exp_ack) begin
            send(ra, 1'b0);
            send(w0[15:8], 1'b0);
            send(w0[7:0], 1'b0);
            if (n > 1) begin
                send(w1[15:8], 1'b0);
                send(w1[7:0], 1'b0);
            end
        end
        i2c_ctrl_model_i.stop_cond();
    endtask

    task automatic read_regs(input logic set_ptr, input logic [7:0] ra,
        output logic [15:0] w0, output logic [15:0] w1);
        if (set_ptr) begin
            i2c_ctrl_model_i.start_cond();
            send({DEV_ADDR_BASE, 1'b0}, 1'b0);
            send(ra, 1'b0);
        end
        i2c_ctrl_model_i.start_cond();
        send({DEV_ADDR_BASE, RW_READ}, 1'b0);
        i2c_ctrl_model_i.get_byte(1'b1, w0[15:8]);
        i2c_ctrl_model_i.get_byte(1'b1, w0[7:0]);
        i2c_ctrl_model_i.get_byte(1'b1, w1[15:8]);
        i2c_ctrl_model_i.get_byte(1'b0, w1[7:0]);
        i2c_ctrl_model_i.stop_cond();
        check("released", {15'h0, sda_oe}, 16'h0000);
    endtask

    task automatic test_reset();
        check("setup", {12'h0, driver_setup}, {12'h0, DRV_SETUP_RESET[3:0]});
        check("busy", {15'h0, bus_busy}, 16'h0000);
        check("oe", {15'h0, sda_oe}, 16'h0000);
        $display("test_reset done");
    endtask

    task automatic test_codes();
        logic [15:0] vals [3];
        logic [15:0] w0;
        logic [15:0] w1;
        vals = '{16'hfffe, 16'h0006, 16'hfff0};
        foreach (vals[i]) begin
            write_regs(DEV_ADDR_BASE, DRV_SETUP_OFFSET, vals[i], 16'h0, 1, 1'b0);
            check("setup", {12'h0, driver_setup}, vals[i] & 16'h000f);
            read_regs(1'b1, DRV_SETUP_OFFSET, w0, w1);
            check("readback", w0, vals[i] & 16'h000f);
            check("next word", w1, UNMAPPED_READ);
        end
        $display("test_codes done");
    endtask

    task automatic test_foreign();
        // Refused address, then a repeated START to our own address
        i2c_ctrl_model_i.start_cond();
        send({DEV_ADDR_BASE ^ 7'h01, 1'b0}, 1'b1);
        write_regs(DEV_ADDR_BASE, DRV_SETUP_OFFSET, 16'h0009, 16'h0, 1, 1'b0);
        check("setup", {12'h0, driver_setup}, 16'h0009);
        write_regs(DEV_ADDR_BASE ^ 7'h01, DRV_SETUP_OFFSET, 16'h0003, 16'h0, 1, 1'b1);
        check("setup", {12'h0, driver_setup}, 16'h0009);
        check("busy", {15'h0, bus_busy}, 16'h0000);
        $display("test_foreign done");
    endtask

    task automatic test_pins();
        logic [6:0] table_addr [4];
        table_addr = '{7'h60, 7'h62, 7'h68, 7'h6a};
        for (int p = 0; p < 4; p++) begin
            @(posedge clk);
            #1;
            {sel_high, sel_low} = p[1:0];
            repeat (4) @(posedge clk);
            foreach (table_addr[a]) begin
                i2c_ctrl_model_i.start_cond();
                send({table_addr[a], 1'b0}, a != p);
                i2c_ctrl_model_i.stop_cond();
            end
        end
        @(posedge clk);
        #1;
        {sel_high, sel_low} = 2'h0;
        repeat (4) @(posedge clk);
        $display("test_pins done");
    endtask

    task automatic test_incr();
        logic [15:0] w0;
        logic [15:0] w1;
        write_regs(DEV_ADDR_BASE, DRV_SETUP_OFFSET - 8'h01, 16'h1234, 16'h000e, 2, 1'b0);
        check("setup", {12'h0, driver_setup}, 16'h000e);
        write_regs(DEV_ADDR_BASE, DRV_SETUP_OFFSET - 8'h01, 16'h5678, 16'h0, 1, 1'b0);
        read_regs(1'b0, 8'h00, w0, w1);
        check("plain read", w0, 16'h000e);
        check("following", w1, UNMAPPED_READ);
        $display("test_incr done");
    endtask

    // Frozen target ignores the bus; a later reset restores the setup word
    task automatic test_freeze();
        logic ack;
        @(posedge clk);
        #1;
        clk_en = 1'b0;
        i2c_ctrl_model_i.start_cond();
        i2c_ctrl_model_i.put_byte({DEV_ADDR_BASE, 1'b0}, ack);
        i2c_ctrl_model_i.stop_cond();
        check("frozen ack", {15'h0, ack}, 16'h0001);
        check("frozen setup", {12'h0, driver_setup}, 16'h000e);
        @(posedge clk);
        #1;
        clk_en = 1'b1;
        reset = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        reset = 1'b0;
        repeat (4) @(posedge clk);
        check("setup", {12'h0, driver_setup}, {12'h0, DRV_SETUP_RESET[3:0]});
        check("busy", {15'h0, bus_busy}, 16'h0000);
        $display("test_freeze done");
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        reset = 1'b1;
        clk_en = 1'b1;
        sel_low = 1'b0;
        sel_high = 1'b0;
        repeat (16) @(posedge clk);
        #1;
        reset = 1'b0;
        repeat (4) @(posedge clk);
        test_reset();
        test_codes();
        test_foreign();
        test_pins();
        test_incr();
        test_freeze();
        stop_test();
    end

    initial begin
        repeat (90000) @(posedge clk);
        n_fail++;
        $display("BAD watchdog expected finish seen timeout");
        stop_test();
    end
endmodule
`default_nettype wire
